// ### rcrb_bank.sv
// Receiver control register bank: command, frequency, on/off, pattern and strength registers
`timescale 1ns/100ps
module rcrb_bank (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register access port
    input  wire logic        accWrite,
    input  wire logic        accRead,
    input  wire logic        accBank,
    input  wire logic [4:0]  accAddr,
    input  wire logic [7:0]  accWrData,
    output logic      [7:0]  accRdData,
    output logic             accRdValid,
    // Context from the preceding configuration registers
    input  wire logic [1:0]  dataRateSel,
    input  wire logic [1:0]  avgFilterCutoffSel,
    input  wire logic        modulationSel,
    input  wire logic        freqWordMode,
    input  wire logic [1:0]  bandCode,
    // Converter results
    input  wire logic [3:0]  lnaLevel,
    input  wire logic [3:0]  ifLevel,
    // Controls to the analog and timing blocks
    output logic [1:0]       avgFilterCutoff,
    output logic             ifGainAttenuate,
    output logic             signalStrengthEnable,
    output logic             envelopeDecaySel,
    output logic             gainLoopReset,
    output logic             gainLoopFreeze,
    output logic             bankSelect,
    output logic [11:0]      loWord,
    output logic             loAddIf,
    output logic [12:0]      freqStepDiv,
    output logic [12:0]      rxOnCycles,
    output logic [5:0]       rxOffPeriods,
    output logic [2:0]       identLength,
    output logic [5:0]       identPattern,
    output logic [2:0]       hdrLength,
    output logic [5:0]       hdrPattern
);
    rcrb_pkg::rcrb_state_t state;
    logic        memWrEn;
    logic [7:0]  memWrData;
    logic [7:0]  memRdData;
    logic [4:0]  rdAddrHold;
    logic        activeBank;
    logic [7:0]  cmdA;
    logic [7:0]  freqHi;
    logic [7:0]  freqLo;
    logic [7:0]  onOff;
    logic [7:0]  ident;
    logic [7:0]  hdr;
    logic [7:0]  strength;

    // Maps a write onto the register, keeping read-only and unused bits
    function automatic logic [7:0] merge_write(input logic [4:0] a, input logic [7:0] d,
                                               input logic [7:0] old);
        case (a)
            rcrb_pkg::ADDR_CMD:     merge_write = (d & rcrb_pkg::CMD_WR_MASK)
                                                  | (old & ~rcrb_pkg::CMD_WR_MASK);
            rcrb_pkg::ADDR_FREQ_HI: merge_write = rcrb_pkg::FREQ_HI_FIXED
                                                  | {4'h0, d[3:0]};
            default:                merge_write = d;
        endcase
    endfunction

    function automatic logic mapped(input logic [4:0] a);
        mapped = (a >= rcrb_pkg::ADDR_CMD && a <= rcrb_pkg::ADDR_FREQ_LO)
                 || (a >= rcrb_pkg::ADDR_ONOFF && a < rcrb_pkg::ADDR_STRENGTH);
    endfunction

    // Registers kept in flops for the active controls; memory keeps the bank images
    rcrb_mem u_mem (
        .clk    (clk),
        .rst    (rst),
        .wrEn   (memWrEn),
        .wrBank (accBank),
        .wrAddr (accAddr[3:0]),
        .wrData (memWrData),
        .rdBank (accBank),
        .rdAddr (accAddr[3:0]),
        .rdData (memRdData)
    );

    // Control images of the active bank, mirrored from writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdA   <= rcrb_pkg::CMD_RESET;
            freqHi <= rcrb_pkg::FREQ_HI_RESET;
            freqLo <= rcrb_pkg::FREQ_LO_RESET;
            onOff  <= rcrb_pkg::ONOFF_RESET;
            ident  <= rcrb_pkg::IDENT_RESET;
            hdr    <= rcrb_pkg::HDR_RESET;
        end else if (memWrEn && accBank == activeBank) begin
            case (accAddr)
                rcrb_pkg::ADDR_CMD:     cmdA   <= memWrData;
                rcrb_pkg::ADDR_FREQ_HI: freqHi <= memWrData;
                rcrb_pkg::ADDR_FREQ_LO: freqLo <= memWrData;
                rcrb_pkg::ADDR_ONOFF:   onOff  <= memWrData;
                rcrb_pkg::ADDR_IDENT:   ident  <= memWrData;
                rcrb_pkg::ADDR_HDR:     hdr    <= memWrData;
                default:                ;
            endcase
        end
    end

    // Active bank follows the select bit written in either bank
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            activeBank <= 1'b0;
        end else if (memWrEn && accAddr == rcrb_pkg::ADDR_ONOFF) begin
            activeBank <= memWrData[rcrb_pkg::ONOFF_BANK];
        end
    end

    // Write merge: the old value of masked bits comes from the mirror
    always_comb begin
        memWrEn   = accWrite && mapped(accAddr);
        memWrData = merge_write(accAddr, accWrData, cmdA);
    end

    // Access sequencer: read data leave one cycle after the memory read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= rcrb_pkg::RCRB_IDLE;
            rdAddrHold <= 5'h00;
        end else begin
            case (state)
                rcrb_pkg::RCRB_IDLE: begin
                    if (accRead) begin
                        state      <= rcrb_pkg::RCRB_READ;
                        rdAddrHold <= accAddr;
                    end else if (accWrite) begin
                        state <= rcrb_pkg::RCRB_WRITE;
                    end
                end
                rcrb_pkg::RCRB_READ:  state <= rcrb_pkg::RCRB_IDLE;
                rcrb_pkg::RCRB_WRITE: state <= rcrb_pkg::RCRB_IDLE;
                default:              state <= rcrb_pkg::RCRB_IDLE;
            endcase
        end
    end

    // Strength is sampled live; bank indicator is shared by both banks
    always_comb begin
        strength = {lnaLevel, ifLevel};
    end

    // Read answer assembly
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accRdData  <= 8'h00;
            accRdValid <= 1'b0;
        end else begin
            accRdValid <= (state == rcrb_pkg::RCRB_READ);
            if (state == rcrb_pkg::RCRB_READ) begin
                case (rdAddrHold)
                    rcrb_pkg::ADDR_CMD:      accRdData <= {memRdData[7:1], ~activeBank};
                    rcrb_pkg::ADDR_STRENGTH: accRdData <= strength;
                    default:                 accRdData <= mapped(rdAddrHold) ? memRdData
                                                          : 8'h00;
                endcase
            end
        end
    end

    // Decoded controls, all from flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avgFilterCutoff      <= 2'h0;
            ifGainAttenuate      <= 1'b0;
            signalStrengthEnable <= 1'b0;
            envelopeDecaySel     <= 1'b1;
            gainLoopReset        <= 1'b0;
            gainLoopFreeze       <= 1'b0;
            bankSelect           <= 1'b0;
        end else begin
            avgFilterCutoff      <= cmdA[rcrb_pkg::CMD_AVG_OVR] ? avgFilterCutoffSel
                                    : dataRateSel;
            ifGainAttenuate      <= cmdA[rcrb_pkg::CMD_IF_ATT] && !modulationSel;
            signalStrengthEnable <= cmdA[rcrb_pkg::CMD_SS_EN];
            envelopeDecaySel     <= cmdA[rcrb_pkg::CMD_ENV_DEC];
            gainLoopReset        <= cmdA[rcrb_pkg::CMD_GAIN_RST];
            gainLoopFreeze       <= cmdA[rcrb_pkg::CMD_GAIN_FRZ];
            bankSelect           <= activeBank;
        end
    end

    // Synthesizer word and step; host does the encoding
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loWord      <= 12'h800;
            loAddIf     <= 1'b1;
            freqStepDiv <= 13'h1000;
        end else begin
            loWord      <= {freqHi[3:0], freqLo};
            loAddIf     <= !freqWordMode;
            freqStepDiv <= (bandCode == 2'b11) ? 13'(rcrb_pkg::FREQ_DIV)
                           : 13'(2 * rcrb_pkg::FREQ_DIV);
        end
    end

    // Strobe timing and pattern lengths
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxOnCycles   <= 13'h1E00;
            rxOffPeriods <= 6'h3F;
            identLength  <= 3'h6;
            identPattern <= 6'h00;
            hdrLength    <= 3'h4;
            hdrPattern   <= 6'h00;
        end else begin
            rxOnCycles <= 13'(onOff[6:3] * rcrb_pkg::ON_UNIT_CYCLES);
            case (onOff[2:0])
                3'h0:    rxOffPeriods <= 6'h01;
                3'h1:    rxOffPeriods <= 6'h02;
                3'h2:    rxOffPeriods <= 6'h04;
                3'h3:    rxOffPeriods <= 6'h08;
                3'h4:    rxOffPeriods <= 6'h0C;
                3'h5:    rxOffPeriods <= 6'h10;
                3'h6:    rxOffPeriods <= 6'h20;
                default: rxOffPeriods <= 6'h3F;
            endcase
            case (ident[7:6])
                2'h0:    identLength <= 3'h2;
                2'h1:    identLength <= 3'h4;
                2'h2:    identLength <= 3'h5;
                default: identLength <= 3'h6;
            endcase
            identPattern <= ident[5:0];
            case (hdr[7:6])
                2'h0:    hdrLength <= 3'h1;
                2'h1:    hdrLength <= 3'h2;
                2'h2:    hdrLength <= 3'h4;
                default: hdrLength <= 3'h6;
            endcase
            hdrPattern <= hdr[5:0];
        end
    end

    // Checks
    property p_filter;
        @(posedge clk) disable iff (rst)
        1'b1 |=> avgFilterCutoff == ($past(cmdA[7]) ? $past(avgFilterCutoffSel)
                                                    : $past(dataRateSel));
    endproperty
    a_filter: assert property (p_filter) else $error("cutoff source wrong");
    property p_ifatt;
        @(posedge clk) disable iff (rst) modulationSel |=> !ifGainAttenuate;
    endproperty
    a_ifatt: assert property (p_ifatt) else $error("attenuation in FSK");
    property p_ss;
        @(posedge clk) disable iff (rst) !cmdA[4] ##1 !cmdA[4] |-> !signalStrengthEnable;
    endproperty
    a_ss: assert property (p_ss) else $error("strength enabled while off");
    property p_ind;
        @(posedge clk) disable iff (rst)
        state == rcrb_pkg::RCRB_READ && rdAddrHold == rcrb_pkg::ADDR_CMD
        |=> accRdValid && accRdData[0] == !$past(activeBank);
    endproperty
    a_ind: assert property (p_ind) else $error("bank indicator wrong");
    sequence s_rd_str;
        state == rcrb_pkg::RCRB_READ && rdAddrHold == rcrb_pkg::ADDR_STRENGTH;
    endsequence
    property p_str;
        @(posedge clk) disable iff (rst) s_rd_str |=> accRdData == $past(strength);
    endproperty
    a_str: assert property (p_str) else $error("strength read wrong");
    property p_on;
        @(posedge clk) disable iff (rst) 1'b1 |=> rxOnCycles == {$past(onOff[6:3]), 9'h000};
    endproperty
    a_on: assert property (p_on) else $error("on time wrong");
    property p_mode;
        @(posedge clk) disable iff (rst) freqWordMode ##1 freqWordMode |-> !loAddIf;
    endproperty
    a_mode: assert property (p_mode) else $error("IF added in direct mode");
    property p_hifix;
        @(posedge clk) disable iff (rst) 1'b1 |-> freqHi[7:4] == 4'h4;
    endproperty
    a_hifix: assert property (p_hifix) else $error("unused bits changed");
endmodule

// ### rcrb_host.sv
// Host model that issues register reads and writes to the receiver bank
`timescale 1ns/100ps
module rcrb_host (
    // Clock
    input  wire logic       clk,
    // Access port
    output logic            accWrite,
    output logic            accRead,
    output logic            accBank,
    output logic      [4:0] accAddr,
    output logic      [7:0] accWrData,
    input  wire logic [7:0] accRdData,
    input  wire logic       accRdValid
);
    // Quiet port at start
    initial begin
        accWrite  = 1'b0;
        accRead   = 1'b0;
        accBank   = 1'b0;
        accAddr   = 5'h00;
        accWrData = 8'h00;
    end

    // Word from frequency given as F*2048/Fref
    function automatic logic [11:0] encWord(input int fq, input logic [1:0] band);
        int w;
        w = (band == 2'b11) ? fq - 35 * 2048 : 2 * fq - 35 * 2048;
        return w[11:0];
    endfunction

    // One write; lines scrambled after so stale values never look valid
    task automatic wr(input logic b, input logic [4:0] a, input logic [7:0] d);
        if (a == rcrb_pkg::ADDR_ONOFF && d[6:3] == 4'h0) begin
            $display("host skips zero on-count at %0t", $time);
        end else begin
            @(posedge clk);
            accBank   <= b;
            accAddr   <= a;
            accWrData <= d;
            accWrite  <= 1'b1;
            @(posedge clk);
            accWrite  <= 1'b0;
            accAddr   <= ~a;
            accWrData <= ~d;
        end
    endtask

    // One read; bounded wait, unknown data if no answer
    task automatic rd(input logic b, input logic [4:0] a, output logic [7:0] d);
        d = 8'hXX;
        @(posedge clk);
        accBank <= b;
        accAddr <= a;
        accRead <= 1'b1;
        @(posedge clk);
        accRead <= 1'b0;
        accAddr <= ~a;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            if (accRdValid === 1'b1) begin
                d = accRdData;
                break;
            end
        end
    endtask
endmodule

// ### rcrb_mem.sv
// Small two-bank register storage with registered read data
`timescale 1ns/100ps
module rcrb_mem (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Write port
    input  wire logic       wrEn,
    input  wire logic       wrBank,
    input  wire logic [3:0] wrAddr,
    input  wire logic [7:0] wrData,
    // Read port
    input  wire logic       rdBank,
    input  wire logic [3:0] rdAddr,
    output logic      [7:0] rdData
);
    logic [7:0] mem [2][16];

    // Bank images start at their documented defaults
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < 16; i++) begin
                    mem[b][i] <= 8'h00;
                end
                mem[b][rcrb_pkg::ADDR_CMD[3:0]]     <= rcrb_pkg::CMD_RESET;
                mem[b][rcrb_pkg::ADDR_FREQ_HI[3:0]] <= rcrb_pkg::FREQ_HI_RESET;
                mem[b][rcrb_pkg::ADDR_FREQ_LO[3:0]] <= rcrb_pkg::FREQ_LO_RESET;
                mem[b][rcrb_pkg::ADDR_ONOFF[3:0]]   <= rcrb_pkg::ONOFF_RESET;
                mem[b][rcrb_pkg::ADDR_IDENT[3:0]]   <= rcrb_pkg::IDENT_RESET;
                mem[b][rcrb_pkg::ADDR_HDR[3:0]]     <= rcrb_pkg::HDR_RESET;
            end
        end else if (wrEn) begin
            mem[wrBank][wrAddr] <= wrData;
        end
    end

    // Registered read keeps the output free of address glitches
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData <= 8'h00;
        end else begin
            rdData <= mem[rdBank][rdAddr];
        end
    end
endmodule

// ### rcrb_pkg.sv
// Package of offsets, field positions, reset values and timing for the receiver register bank
package rcrb_pkg;
    // Register offsets (byte addresses within the bank)
    localparam logic [4:0] ADDR_CMD      = 5'h03;
    localparam logic [4:0] ADDR_FREQ_HI  = 5'h04;
    localparam logic [4:0] ADDR_FREQ_LO  = 5'h05;
    localparam logic [4:0] ADDR_ONOFF    = 5'h09;
    localparam logic [4:0] ADDR_IDENT    = 5'h0A;
    localparam logic [4:0] ADDR_HDR      = 5'h0B;
    localparam logic [4:0] ADDR_STRENGTH = 5'h0C;
    // Command register field positions
    localparam int CMD_AVG_OVR  = 7;
    localparam int CMD_IF_ATT   = 6;
    localparam int CMD_SS_EN    = 4;
    localparam int CMD_ENV_DEC  = 3;
    localparam int CMD_GAIN_RST = 2;
    localparam int CMD_GAIN_FRZ = 1;
    localparam int CMD_BANK_IND = 0;
    localparam logic [7:0] CMD_WR_MASK = 8'hDE;
    // On/off register field positions
    localparam int ONOFF_BANK = 7;
    localparam int ONOFF_ON_LSB = 3;
    // Reset values
    localparam logic [7:0] CMD_RESET     = 8'h08;
    localparam logic [7:0] FREQ_HI_RESET = 8'h48;
    localparam logic [7:0] FREQ_LO_RESET = 8'h00;
    localparam logic [7:0] ONOFF_RESET   = 8'h7F;
    localparam logic [7:0] IDENT_RESET   = 8'hC0;
    localparam logic [7:0] HDR_RESET     = 8'h80;
    localparam logic [7:0] FREQ_HI_FIXED = 8'h40;
    // Timing: on time unit in digital clock periods
    localparam int ON_UNIT_CYCLES = 512;
    // Frequency arithmetic constants
    localparam int FREQ_BASE = 35;
    localparam int FREQ_DIV  = 2048;
    // Number of registers in each bank image
    localparam int NREG = 13;
    // Access sequencer states
    typedef enum logic [2:0] {
        RCRB_IDLE  = 3'b001,
        RCRB_WRITE = 3'b010,
        RCRB_READ  = 3'b100
    } rcrb_state_t;
endpackage

// ### rcrb_tb.sv
// Self-checking bench for the receiver control register bank
`timescale 1ns/100ps
module tb;
    logic        clk;
    logic        rst;
    logic        accWrite;
    logic        accRead;
    logic        accBank;
    logic [4:0]  accAddr;
    logic [7:0]  accWrData;
    logic [7:0]  accRdData;
    logic        accRdValid;
    logic [1:0]  dataRateSel;
    logic [1:0]  avgFilterCutoffSel;
    logic        modulationSel;
    logic        freqWordMode;
    logic [1:0]  bandCode;
    logic [3:0]  lnaLevel;
    logic [3:0]  ifLevel;
    logic [1:0]  avgFilterCutoff;
    logic        ifGainAttenuate;
    logic        signalStrengthEnable;
    logic        envelopeDecaySel;
    logic        gainLoopReset;
    logic        gainLoopFreeze;
    logic        bankSelect;
    logic [11:0] loWord;
    logic        loAddIf;
    logic [12:0] freqStepDiv;
    logic [12:0] rxOnCycles;
    logic [5:0]  rxOffPeriods;
    logic [2:0]  identLength;
    logic [5:0]  identPattern;
    logic [2:0]  hdrLength;
    logic [5:0]  hdrPattern;
    logic [7:0]  ctl;
    logic [7:0]  d;
    int          err_count;
    int          compares;
    int          offTab[8] = '{1, 2, 4, 8, 12, 16, 32, 63};
    int          idTab[4]  = '{2, 4, 5, 6};
    int          hdTab[4]  = '{1, 2, 4, 6};

    // Control outputs gathered for compact compares
    assign ctl = {avgFilterCutoff, ifGainAttenuate, signalStrengthEnable,
                  envelopeDecaySel, gainLoopReset, gainLoopFreeze, bankSelect};

    rcrb_bank dut_u (.clk(clk), .rst(rst), .accWrite(accWrite), .accRead(accRead),
        .accBank(accBank), .accAddr(accAddr), .accWrData(accWrData), .accRdData(accRdData),
        .accRdValid(accRdValid), .dataRateSel(dataRateSel),
        .avgFilterCutoffSel(avgFilterCutoffSel), .modulationSel(modulationSel),
        .freqWordMode(freqWordMode), .bandCode(bandCode), .lnaLevel(lnaLevel),
        .ifLevel(ifLevel), .avgFilterCutoff(avgFilterCutoff),
        .ifGainAttenuate(ifGainAttenuate), .signalStrengthEnable(signalStrengthEnable),
        .envelopeDecaySel(envelopeDecaySel), .gainLoopReset(gainLoopReset),
        .gainLoopFreeze(gainLoopFreeze), .bankSelect(bankSelect), .loWord(loWord),
        .loAddIf(loAddIf), .freqStepDiv(freqStepDiv), .rxOnCycles(rxOnCycles),
        .rxOffPeriods(rxOffPeriods), .identLength(identLength),
        .identPattern(identPattern), .hdrLength(hdrLength), .hdrPattern(hdrPattern));

    rcrb_host host_u (.clk(clk), .accWrite(accWrite), .accRead(accRead),
        .accBank(accBank), .accAddr(accAddr), .accWrData(accWrData),
        .accRdData(accRdData), .accRdValid(accRdValid));

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic chk(input logic [15:0] act, input logic [15:0] exp);
        compares++;
        if (act !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    // Outputs follow one cycle after the write lands
    task automatic settle();
        repeat (2) @(negedge clk);
    endtask

    task automatic t_command();
        @(posedge clk);
        dataRateSel        <= 2'h2;
        avgFilterCutoffSel <= 2'h1;
        modulationSel      <= 1'b0;
        host_u.wr(1'b0, 5'h03, 8'hFF);
        settle();
        chk(ctl, 8'h7E);
        host_u.rd(1'b0, 5'h03, d);
        chk(d, 8'hDF);
        @(posedge clk);
        modulationSel <= 1'b1;
        host_u.wr(1'b0, 5'h0A, 8'hC0);
        settle();
        chk(ctl, 8'h5E);
        host_u.wr(1'b0, 5'h03, 8'h00);
        settle();
        chk(ctl, 8'h80);
    endtask

    task automatic t_freq();
        logic [11:0] w;
        w = host_u.encWord(35 * 2048 + 12'hA5C, 2'b11);
        host_u.wr(1'b0, 5'h04, {4'hF, w[11:8]});
        host_u.wr(1'b0, 5'h05, w[7:0]);
        host_u.rd(1'b0, 5'h04, d);
        chk(d, {4'h4, w[11:8]});
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            bandCode     <= (i >= 2) ? 2'b11 : i[1:0];
            freqWordMode <= i[0];
            settle();
            chk({3'h0, freqStepDiv}, (i >= 2) ? 16'h0800 : 16'h1000);
            chk({loAddIf, 3'h0, loWord}, {~i[0], 15'hA5C});
        end
    endtask

    task automatic t_onoff();
        logic [3:0] n;
        for (int i = 0; i < 8; i++) begin
            n = 4'(2 * i + 1);
            host_u.wr(1'b0, 5'h09, {1'b0, n, i[2:0]});
            settle();
            chk({3'h0, rxOnCycles}, 16'(n * 512));
            chk({10'h0, rxOffPeriods}, 16'(offTab[i]));
        end
    endtask

    task automatic t_patterns();
        for (int i = 0; i < 4; i++) begin
            host_u.wr(1'b0, 5'h0A, {i[1:0], 6'h25 ^ 6'(i)});
            host_u.wr(1'b0, 5'h0B, {i[1:0], 6'h1A ^ 6'(i)});
            settle();
            chk({identLength, identPattern}, {3'(idTab[i]), 6'h25 ^ 6'(i)});
            chk({hdrLength, hdrPattern}, {3'(hdTab[i]), 6'h1A ^ 6'(i)});
        end
    endtask

    task automatic t_strength();
        host_u.wr(1'b0, 5'h0C, 8'hFF);
        host_u.rd(1'b0, 5'h0C, d);
        chk(d, 8'hA3);
        @(posedge clk);
        lnaLevel <= 4'h5;
        ifLevel  <= 4'hC;
        host_u.rd(1'b1, 5'h0C, d);
        chk(d, 8'h5C);
        host_u.rd(1'b0, 5'h1F, d);
        chk(d, 8'h00);
    endtask

    // Switch to the second bank; only its writes, and on/off writes to either bank, steer the controls
    task automatic t_bank();
        host_u.wr(1'b0, 5'h09, 8'hAA);
        host_u.wr(1'b1, 5'h03, 8'h10);
        host_u.wr(1'b0, 5'h03, 8'h80);
        settle();
        chk(ctl, 8'h91);
        host_u.rd(1'b0, 5'h03, d);
        chk(d[0], 1'b0);
        host_u.rd(1'b1, 5'h03, d);
        chk(d[0], 1'b0);
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence: reset, reset values, then each scenario
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        err_count = 0;
        compares = 0;
        {dataRateSel, avgFilterCutoffSel, modulationSel, freqWordMode, bandCode} = '0;
        lnaLevel = 4'hA;
        ifLevel = 4'h3;
        repeat (12) @(posedge clk);
        chk(ctl, 8'h08);
        chk({3'h0, rxOnCycles}, 16'h1E00);
        chk({rxOffPeriods, identLength, hdrLength}, {6'h3F, 3'h6, 3'h4});
        chk({loAddIf, freqStepDiv, loWord}, {1'b1, 13'h1000, 12'h800});
        rst <= 1'b0;
        host_u.rd(1'b0, 5'h03, d);
        chk(d, 8'h09);
        host_u.rd(1'b1, 5'h04, d);
        chk(d, 8'h48);
        host_u.rd(1'b0, 5'h0B, d);
        chk(d, 8'h80);
        t_command();
        t_freq();
        t_onoff();
        t_patterns();
        t_strength();
        t_bank();
        summarize();
    end

    // Watchdog well beyond the 35 accesses above
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule
